// ===== rtl/rct_pkg.sv
package rct_pkg;

    localparam int NUM_TIMERS = 3;
    localparam int CNT_W = 16;

    // Register offsets inside each timer's page.
    localparam logic [7:0] OFF_CONTROL = 8'hc8;
    localparam logic [7:0] OFF_CONFIG = 8'hc9;
    localparam logic [7:0] OFF_RELOAD_LO = 8'hca;
    localparam logic [7:0] OFF_RELOAD_HI = 8'hcb;
    localparam logic [7:0] OFF_COUNT_LO = 8'hcc;
    localparam logic [7:0] OFF_COUNT_HI = 8'hcd;

    // Control register fields.
    localparam int CN_WRAP_FLAG = 7;
    localparam int CN_EXT_FLAG = 6;
    localparam int CN_EXT_ENABLE = 3;
    localparam int CN_RUN = 2;
    localparam int CN_COUNTER_SEL = 1;
    localparam int CN_CAPTURE_SEL = 0;

    // Configuration register fields.
    localparam int CF_MODE_HI = 4;
    localparam int CF_MODE_LO = 3;
    localparam int CF_TOGGLE_STATE = 2;
    localparam int CF_TOGGLE_OE = 1;
    localparam int CF_DECREMENT = 0;

    // Timer clock mode encodings.
    localparam logic [1:0] MODE_DIV12 = 2'h0;
    localparam logic [1:0] MODE_SYSTEM_CLOCK = 2'h1;
    localparam logic [1:0] MODE_EXT_DIV8 = 2'h2;
    localparam logic [1:0] MODE_DIV2 = 2'h3;

    localparam logic [3:0] DIV12_LAST = 4'hb;
    localparam logic [2:0] EXT_DIV8_LAST = 3'h7;

    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam logic [15:0] COUNT_MIN = 16'h0000;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] RELOAD_RESET = 16'h0000;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // Only the first and third timers own a toggle output.
    localparam logic [NUM_TIMERS-1:0] TOGGLE_CAPABLE = 3'h5;

endpackage

// ===== rtl/rct_timer_block.sv
`timescale 1ns/1ps
//Contract
// - Capture falling ext edge copies count.
// - Capture sets external flag, requests interrupt.
// - Count overflow sets wrap flag, interrupt.
// - Capture decrement wraps 0000 to FFFF, flagged.
// - Capture needs select, run; ext enable.
// - Reload up overflow loads reload, flags.
// - Reload ext falling edge reloads count.
// - Decrement enable: pin only sets direction.
// - Reload down match loads FFFF, flags.
// - Select clear means reload; run starts.
// - Reload wrap toggles external flag, 17th bit.
// - Toggle pin inverts on every reload-mode wrap while toggle output is enabled, except when a config write forces it that cycle.
// - Toggle state reads level, write forces.
// - Toggle reload values by count direction.
// - Second timer shares first timer's pin.
// - Pin high counts up, low down.
// - Counter select: count pin falls advance.
module rct_timer_block
    import rct_pkg::*;
(
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic [1:0] sfr_page_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] sfr_rdata_o,
    input wire logic ext_clock_i,
    input wire logic [1:0] count_pin_i,
    input wire logic [1:0] external_enable_pin_i,
    output logic [1:0] count_output_pin_o,
    output logic [1:0] count_output_en_o,
    output logic [NUM_TIMERS-1:0] timer_irq_o
);

    function automatic logic reg_hit(input logic [1:0] page, input logic [7:0] addr, input int idx,
                                     input logic [7:0] off);
        reg_hit = (page == idx[1:0]) && (addr == off);
    endfunction

    // Timers one and two share the first pin pair; timer three has its own.
    localparam int SHARED_PIN = 0;
    localparam int OWN_PIN = 1;
    localparam int OWN_PIN_TIMER = 2;
    function automatic int pin_of(input int idx);
        pin_of = (idx == OWN_PIN_TIMER) ? OWN_PIN : SHARED_PIN;
    endfunction

    // Pins idle high, so resetting the stages to one keeps a release from faking a falling edge.
    localparam logic [1:0] PIN_IDLE = 2'h3;

    // Pin synchronisers: two stages, then a third stage for edge detection.
    logic [1:0] cpin_s1_r, cpin_s2_r, cpin_d_r;
    logic [1:0] epin_s1_r, epin_s2_r, epin_d_r;
    logic xclk_s1_r, xclk_s2_r, xclk_d_r;

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cpin_s1_r <= PIN_IDLE;
            cpin_s2_r <= PIN_IDLE;
            cpin_d_r <= PIN_IDLE;
            epin_s1_r <= PIN_IDLE;
            epin_s2_r <= PIN_IDLE;
            epin_d_r <= PIN_IDLE;
            xclk_s1_r <= 1'b0;
            xclk_s2_r <= 1'b0;
            xclk_d_r <= 1'b0;
        end else begin
            cpin_s1_r <= count_pin_i;
            cpin_s2_r <= cpin_s1_r;
            cpin_d_r <= cpin_s2_r;
            epin_s1_r <= external_enable_pin_i;
            epin_s2_r <= epin_s1_r;
            epin_d_r <= epin_s2_r;
            xclk_s1_r <= ext_clock_i;
            xclk_s2_r <= xclk_s1_r;
            xclk_d_r <= xclk_s2_r;
        end
    end

    logic [1:0] cpin_fall, epin_fall;
    assign cpin_fall = cpin_d_r & ~cpin_s2_r;
    assign epin_fall = epin_d_r & ~epin_s2_r;

    // Shared prescalers produce one-cycle enables for the timer clock.
    // They run free, so the first tick after a start may come up to one period early.
    logic [3:0] div12_r;
    logic div2_r;
    logic [2:0] xdiv_r;
    logic en_div12_r, en_xdiv_r;

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            div12_r <= 4'h0;
            en_div12_r <= 1'b0;
        end else begin
            en_div12_r <= (div12_r == DIV12_LAST);
            div12_r <= (div12_r == DIV12_LAST) ? 4'h0 : div12_r + 4'h1;
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            div2_r <= 1'b0;
        end else begin
            div2_r <= ~div2_r;
        end
    end

    // The external clock is only counted after synchronising, so it must run below half the system clock.
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            xdiv_r <= 3'h0;
            en_xdiv_r <= 1'b0;
        end else begin
            en_xdiv_r <= xclk_s2_r && !xclk_d_r && (xdiv_r == EXT_DIV8_LAST);
            if (xclk_s2_r && !xclk_d_r) begin
                xdiv_r <= xdiv_r + 3'h1;
            end
        end
    end

    logic [3:0] mode_en;
    always_comb begin
        mode_en = 4'h0;
        mode_en[MODE_DIV12] = en_div12_r;
        mode_en[MODE_SYSTEM_CLOCK] = 1'b1;
        mode_en[MODE_EXT_DIV8] = en_xdiv_r;
        mode_en[MODE_DIV2] = div2_r;
    end

    // Per-timer state.
    logic [NUM_TIMERS-1:0] wrap_flag_r, ext_flag_r, ext_req_r, ext_en_r, run_r, ctr_sel_r, cap_sel_r;
    logic [NUM_TIMERS-1:0] tog_r, toe_r, dcen_r;
    logic [1:0] mode_r [NUM_TIMERS];
    logic [15:0] rcap_r [NUM_TIMERS];
    logic [15:0] cnt_r [NUM_TIMERS];

    logic [NUM_TIMERS-1:0] wrap_flag_nxt, ext_flag_nxt, ext_req_nxt, tog_nxt;
    logic [15:0] rcap_nxt [NUM_TIMERS];
    logic [15:0] cnt_nxt [NUM_TIMERS];
    logic [NUM_TIMERS-1:0] we_ctl, we_cfg;

    always_comb begin
        for (int i = 0; i < NUM_TIMERS; i++) begin
            logic tick, up, edge_evt, wrap, ext_lvl;
            tick = 1'b0;
            up = 1'b1;
            edge_evt = 1'b0;
            wrap = 1'b0;
            ext_lvl = epin_s2_r[pin_of(i)];
            we_ctl[i] = sfr_wr_i && reg_hit(sfr_page_i, sfr_addr_i, i, OFF_CONTROL);
            we_cfg[i] = sfr_wr_i && reg_hit(sfr_page_i, sfr_addr_i, i, OFF_CONFIG);

            tick = ctr_sel_r[i] ? cpin_fall[pin_of(i)] : mode_en[mode_r[i]];
            up = !dcen_r[i] || ext_lvl;
            // With decrement enabled the pin is a direction level only.
            edge_evt = run_r[i] && ext_en_r[i] && !dcen_r[i] && epin_fall[pin_of(i)];
            if (run_r[i] && tick) begin
                if (up) begin
                    wrap = (cnt_r[i] == COUNT_MAX);
                end else if (cap_sel_r[i]) begin
                    wrap = (cnt_r[i] == COUNT_MIN);
                end else begin
                    wrap = (cnt_r[i] == rcap_r[i]);
                end
            end

            cnt_nxt[i] = cnt_r[i];
            if (run_r[i] && tick) begin
                if (up) begin
                    cnt_nxt[i] = (wrap && !cap_sel_r[i]) ? rcap_r[i] : cnt_r[i] + 16'h0001;
                end else begin
                    cnt_nxt[i] = (wrap && !cap_sel_r[i]) ? COUNT_MAX : cnt_r[i] - 16'h0001;
                end
            end
            if (edge_evt && !cap_sel_r[i]) begin
                cnt_nxt[i] = rcap_r[i];
            end
            // Count bytes are written one at a time; software should stop the timer to load both safely.
            if (sfr_wr_i && reg_hit(sfr_page_i, sfr_addr_i, i, OFF_COUNT_LO)) begin
                cnt_nxt[i][7:0] = sfr_wdata_i;
            end
            if (sfr_wr_i && reg_hit(sfr_page_i, sfr_addr_i, i, OFF_COUNT_HI)) begin
                cnt_nxt[i][15:8] = sfr_wdata_i;
            end

            rcap_nxt[i] = rcap_r[i];
            if (sfr_wr_i && reg_hit(sfr_page_i, sfr_addr_i, i, OFF_RELOAD_LO)) begin
                rcap_nxt[i][7:0] = sfr_wdata_i;
            end
            if (sfr_wr_i && reg_hit(sfr_page_i, sfr_addr_i, i, OFF_RELOAD_HI)) begin
                rcap_nxt[i][15:8] = sfr_wdata_i;
            end
            // A capture beats a software write in the same cycle so no event is lost.
            if (edge_evt && cap_sel_r[i]) begin
                rcap_nxt[i] = cnt_r[i];
            end

            // Flags: a hardware set wins over a software clear in the same cycle.
            wrap_flag_nxt[i] = we_ctl[i] ? sfr_wdata_i[CN_WRAP_FLAG] : wrap_flag_r[i];
            if (wrap) begin
                wrap_flag_nxt[i] = 1'b1;
            end
            ext_flag_nxt[i] = we_ctl[i] ? sfr_wdata_i[CN_EXT_FLAG] : ext_flag_r[i];
            ext_req_nxt[i] = ext_req_r[i] && ext_flag_nxt[i];
            // In reload mode the flag is a seventeenth count bit, so its toggle withdraws a pending request.
            if (wrap && !cap_sel_r[i]) begin
                ext_flag_nxt[i] = ~ext_flag_r[i];
                ext_req_nxt[i] = 1'b0;
            end
            if (edge_evt) begin
                ext_flag_nxt[i] = 1'b1;
                ext_req_nxt[i] = 1'b1;
            end

            // The toggle rate follows the reload value and the timer clock; software picks both for the wanted frequency.
            tog_nxt[i] = tog_r[i];
            if (TOGGLE_CAPABLE[i]) begin
                if (wrap && toe_r[i] && !cap_sel_r[i]) begin
                    tog_nxt[i] = ~tog_r[i];
                end
                if (we_cfg[i]) begin
                    tog_nxt[i] = sfr_wdata_i[CF_TOGGLE_STATE];
                end
            end else begin
                tog_nxt[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < NUM_TIMERS; i++) begin
                cnt_r[i] <= COUNT_RESET;
                rcap_r[i] <= RELOAD_RESET;
            end
        end else begin
            for (int i = 0; i < NUM_TIMERS; i++) begin
                cnt_r[i] <= cnt_nxt[i];
                rcap_r[i] <= rcap_nxt[i];
            end
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wrap_flag_r <= '0;
            ext_flag_r <= '0;
            ext_req_r <= '0;
            tog_r <= '0;
        end else begin
            wrap_flag_r <= wrap_flag_nxt;
            ext_flag_r <= ext_flag_nxt;
            ext_req_r <= ext_req_nxt;
            tog_r <= tog_nxt;
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ext_en_r <= '0;
            run_r <= '0;
            ctr_sel_r <= '0;
            cap_sel_r <= '0;
            toe_r <= '0;
            dcen_r <= '0;
            for (int i = 0; i < NUM_TIMERS; i++) begin
                mode_r[i] <= MODE_DIV12;
            end
        end else begin
            for (int i = 0; i < NUM_TIMERS; i++) begin
                if (we_ctl[i]) begin
                    ext_en_r[i] <= sfr_wdata_i[CN_EXT_ENABLE];
                    run_r[i] <= sfr_wdata_i[CN_RUN];
                    ctr_sel_r[i] <= sfr_wdata_i[CN_COUNTER_SEL];
                    cap_sel_r[i] <= sfr_wdata_i[CN_CAPTURE_SEL];
                end
                if (we_cfg[i]) begin
                    mode_r[i] <= sfr_wdata_i[CF_MODE_HI:CF_MODE_LO];
                    toe_r[i] <= sfr_wdata_i[CF_TOGGLE_OE] & TOGGLE_CAPABLE[i];
                    dcen_r[i] <= sfr_wdata_i[CF_DECREMENT];
                end
            end
        end
    end

    // Reads have no side effects, so polling a flag never clears it.
    // Register read data is returned on the edge after the read strobe.
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sfr_rdata_o <= READ_ZERO;
        end else if (sfr_rd_i) begin
            sfr_rdata_o <= READ_ZERO;
            for (int i = 0; i < NUM_TIMERS; i++) begin
                if (sfr_page_i == i[1:0]) begin
                    case (sfr_addr_i)
                        OFF_CONTROL: begin
                            sfr_rdata_o <= READ_ZERO;
                            sfr_rdata_o[CN_WRAP_FLAG] <= wrap_flag_r[i];
                            sfr_rdata_o[CN_EXT_FLAG] <= ext_flag_r[i];
                            sfr_rdata_o[CN_EXT_ENABLE] <= ext_en_r[i];
                            sfr_rdata_o[CN_RUN] <= run_r[i];
                            sfr_rdata_o[CN_COUNTER_SEL] <= ctr_sel_r[i];
                            sfr_rdata_o[CN_CAPTURE_SEL] <= cap_sel_r[i];
                        end
                        OFF_CONFIG: begin
                            sfr_rdata_o <= READ_ZERO;
                            sfr_rdata_o[CF_MODE_HI:CF_MODE_LO] <= mode_r[i];
                            sfr_rdata_o[CF_TOGGLE_STATE] <= tog_r[i];
                            sfr_rdata_o[CF_TOGGLE_OE] <= toe_r[i];
                            sfr_rdata_o[CF_DECREMENT] <= dcen_r[i];
                        end
                        OFF_RELOAD_LO: sfr_rdata_o <= rcap_r[i][7:0];
                        OFF_RELOAD_HI: sfr_rdata_o <= rcap_r[i][15:8];
                        OFF_COUNT_LO: sfr_rdata_o <= cnt_r[i][7:0];
                        OFF_COUNT_HI: sfr_rdata_o <= cnt_r[i][15:8];
                        default: sfr_rdata_o <= READ_ZERO;
                    endcase
                end
            end
        end
    end

    // Interrupt requests and pin enables are registered so the ports never glitch.
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            timer_irq_o <= '0;
            count_output_en_o <= 2'h0;
        end else begin
            timer_irq_o <= wrap_flag_nxt | ext_req_nxt;
            count_output_en_o <= {toe_r[2] & ~cap_sel_r[2], toe_r[0] & ~cap_sel_r[0]};
        end
    end

    // Each pin bit is a flop of its own; the concatenation adds no logic.
    assign count_output_pin_o = {tog_r[2], tog_r[0]};

endmodule

// ===== test/rct_pin_model.sv
`timescale 1ns/1ps
module rct_pin_model (
    input wire logic [1:0] cnt_lvl_i,
    input wire logic [1:0] en_lvl_i,
    output logic ext_clock_o,
    output logic [1:0] count_pin_o,
    output logic [1:0] en_pin_o
);
    // The oscillator runs free at 100 MHz, below half the system clock.
    initial ext_clock_o = 1'b0;
    always #5 ext_clock_o = ~ext_clock_o;
    // Pin 0 feeds timers 0 and 1 alike.
    assign en_pin_o = en_lvl_i;
    assign count_pin_o = cnt_lvl_i;
endmodule

// ===== test/rct_timer_block_props.sv
`timescale 1ns/1ps
module rct_timer_block_props
    import rct_pkg::*;
(
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic [1:0] sfr_page_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic [1:0] count_output_pin_o,
    input wire logic [1:0] count_output_en_o,
    input wire logic [NUM_TIMERS-1:0] timer_irq_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rstn_i);
    wire logic pg0 = sfr_page_i == 2'h0;
    wire logic wr0 = sfr_wr_i && pg0;
    wire logic cfg0 = pg0 && sfr_addr_i == OFF_CONFIG;
    wire logic cfg0_wr = sfr_wr_i && cfg0;
    wire logic ctl0_wr = wr0 && sfr_addr_i == OFF_CONTROL;
    wire logic rd_ok = sfr_rd_i && sfr_page_i != 2'h3;

    a_page3_zero: assert property (sfr_rd_i && sfr_page_i == 2'h3
        |=> sfr_rdata_o == READ_ZERO) else $error("unmapped read not zero");
    a_ctl_resv: assert property (rd_ok && sfr_addr_i == OFF_CONTROL
        |=> sfr_rdata_o[5:4] == 2'h0) else $error("control reserved bits set");
    a_cfg_resv: assert property (rd_ok && sfr_addr_i == OFF_CONFIG
        |=> sfr_rdata_o[7:5] == 3'h0) else $error("config reserved bits set");
    a_t1_no_toggle: assert property (sfr_rd_i && sfr_page_i == 2'h1 && sfr_addr_i == OFF_CONFIG
        |=> sfr_rdata_o[2:1] == 2'h0) else $error("timer 1 toggle bits set");
    a_rdata_hold: assert property (!sfr_rd_i |=> $stable(sfr_rdata_o))
        else $error("read data moved without read");
    a_tog_force: assert property (cfg0_wr
        |=> count_output_pin_o[0] == $past(sfr_wdata_i[CF_TOGGLE_STATE])) else $error("toggle write not forced");
    a_tog_read: assert property (sfr_rd_i && cfg0
        |=> sfr_rdata_o[CF_TOGGLE_STATE] == $past(count_output_pin_o[0])) else $error("toggle read wrong");
    a_pin_cause: assert property ($changed(count_output_pin_o[0])
        |-> count_output_en_o[0] || $past(count_output_en_o[0]) || $past(cfg0_wr)) else $error("pin moved idle");
    a_en_cause: assert property ($rose(count_output_en_o[0])
        |-> $past(wr0) || $past(wr0, 2)) else $error("output enable rose unasked");
    a_irq_sticky: assert property ($fell(timer_irq_o[0])
        |-> $past(ctl0_wr) || $past(ctl0_wr, 2)) else $error("irq dropped without clear");
    c_irq: cover property ($rose(timer_irq_o[2]));
    c_toggle: cover property ($changed(count_output_pin_o[0]) && count_output_en_o[0]);
    c_en: cover property ($rose(count_output_en_o[0]));
endmodule

bind rct_timer_block rct_timer_block_props i_props (.clock_i, .rstn_i, .sfr_page_i, .sfr_addr_i,
    .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o, .count_output_pin_o, .count_output_en_o, .timer_irq_o);

// ===== test/tb_reload_capture_timer.sv
`timescale 1ns/1ps
module tb_reload_capture_timer
    import rct_pkg::*;
;
    typedef struct packed {
        logic [1:0] pg;
        logic [7:0] ad;
        logic w;
        logic [7:0] wd;
        logic [7:0] ex;
    } rct_row_t;
    logic clock_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [1:0] pg = 2'h0;
    logic [7:0] ad = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] wd = 8'h00;
    logic [1:0] cnt_lvl = 2'h3;
    logic [1:0] en_lvl = 2'h3;
    logic ext_clk;
    logic [1:0] cnt_pin;
    logic [1:0] en_pin;
    logic [1:0] pin_o;
    logic [1:0] oe_o;
    logic [2:0] irq;
    logic [7:0] rdata;
    logic [7:0] d;
    int bad_count = 0;
    int tests_run = 0;
    // Ticks seen in a 120-cycle run window for clock modes 00, 01, 10 and 11.
    logic [7:0] mode_ticks [4] = '{8'h0a, 8'h78, 8'h06, 8'h3c};
    rct_row_t rows [11] = '{
        '{2'h0, 8'hc8, 1'b0, 8'h00, 8'h00}, '{2'h2, 8'hcb, 1'b0, 8'h00, 8'h00},
        '{2'h1, 8'hcc, 1'b0, 8'h00, 8'h00}, '{2'h0, 8'hcd, 1'b0, 8'h00, 8'h00},
        '{2'h0, 8'hca, 1'b1, 8'ha5, 8'ha5}, '{2'h2, 8'hcd, 1'b1, 8'hc3, 8'hc3},
        '{2'h0, 8'hc9, 1'b1, 8'hff, 8'h1f}, '{2'h1, 8'hc9, 1'b1, 8'hff, 8'h19},
        '{2'h0, 8'hc8, 1'b1, 8'h3b, 8'h0b}, '{2'h3, 8'hc8, 1'b1, 8'h55, 8'h00},
        '{2'h0, 8'hc7, 1'b1, 8'h77, 8'h00}
    };

    always #2 clock_i = ~clock_i;

    rct_pin_model i_pins (.cnt_lvl_i(cnt_lvl), .en_lvl_i(en_lvl), .ext_clock_o(ext_clk),
        .count_pin_o(cnt_pin), .en_pin_o(en_pin));
    rct_timer_block i_dut (.clock_i(clock_i), .rstn_i(rstn_i), .sfr_page_i(pg), .sfr_addr_i(ad),
        .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_wdata_i(wd), .sfr_rdata_o(rdata), .ext_clock_i(ext_clk),
        .count_pin_i(cnt_pin), .external_enable_pin_i(en_pin), .count_output_pin_o(pin_o),
        .count_output_en_o(oe_o), .timer_irq_o(irq));

    task automatic wr8(input logic [1:0] p, input logic [7:0] a, input logic [7:0] v);
        pg <= p;
        ad <= a;
        wd <= v;
        wr <= 1'b1;
        @(posedge clock_i);
        wr <= 1'b0;
        @(posedge clock_i);
    endtask

    task automatic rd8(input logic [1:0] p, input logic [7:0] a);
        pg <= p;
        ad <= a;
        rd <= 1'b1;
        @(posedge clock_i);
        rd <= 1'b0;
        @(posedge clock_i);
        d = rdata;
    endtask

    task automatic chk(input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    // Bounded so that a silent timer shows up as failed checks, not a hang.
    task automatic wait_irq0;
        int n;
        n = 0;
        while (irq[0] !== 1'b1 && n < 200) begin
            @(posedge clock_i);
            n++;
        end
        chk(8'h01, {7'h0, irq[0]});
    endtask

    task automatic summarize;
        $display("checks=%0d mismatches=%0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (3000) @(posedge clock_i);
        bad_count++;
        $display("watchdog expired");
        summarize();
    end

    initial begin
        repeat (3) @(posedge clock_i);
        rstn_i <= 1'b1;
        @(posedge clock_i);
        foreach (rows[i]) begin
            if (rows[i].w) wr8(rows[i].pg, rows[i].ad, rows[i].wd);
            rd8(rows[i].pg, rows[i].ad);
            chk(rows[i].ex, d);
        end
        $display("test registers done");
        wr8(2'h0, OFF_CONTROL, 8'h00);
        wr8(2'h0, OFF_CONFIG, 8'h0a);
        chk(8'h00, {7'h0, pin_o[0]});
        wr8(2'h0, OFF_RELOAD_LO, 8'hf0);
        wr8(2'h0, OFF_RELOAD_HI, 8'hff);
        wr8(2'h0, OFF_COUNT_LO, 8'hf0);
        wr8(2'h0, OFF_COUNT_HI, 8'hff);
        wr8(2'h0, OFF_CONTROL, 8'h04);
        wait_irq0();
        rd8(2'h0, OFF_CONTROL);
        chk(8'hc4, d);
        wr8(2'h0, OFF_CONTROL, 8'hc0);
        chk(8'h01, {7'h0, oe_o[0]});
        chk(8'h01, {7'h0, pin_o[0]});
        rd8(2'h0, OFF_CONTROL);
        chk(8'hc0, d);
        rd8(2'h0, OFF_COUNT_HI);
        chk(8'hff, d);
        wr8(2'h0, OFF_CONTROL, 8'h00);
        repeat (2) @(posedge clock_i);
        chk(8'h00, {5'h0, irq});
        $display("test reload up done");
        en_lvl <= 2'h2;
        wr8(2'h0, OFF_CONFIG, 8'h09);
        wr8(2'h0, OFF_RELOAD_HI, 8'h01);
        wr8(2'h0, OFF_RELOAD_LO, 8'h00);
        wr8(2'h0, OFF_COUNT_HI, 8'h01);
        wr8(2'h0, OFF_COUNT_LO, 8'h04);
        wr8(2'h0, OFF_CONTROL, 8'h04);
        wait_irq0();
        wr8(2'h0, OFF_CONTROL, 8'h00);
        rd8(2'h0, OFF_COUNT_HI);
        chk(8'hff, d);
        $display("test reload down done");
        wr8(2'h2, OFF_COUNT_LO, 8'h34);
        wr8(2'h2, OFF_COUNT_HI, 8'h12);
        wr8(2'h2, OFF_CONTROL, 8'h07);
        en_lvl <= 2'h0;
        repeat (8) @(posedge clock_i);
        rd8(2'h2, OFF_RELOAD_HI);
        chk(8'h00, d);
        en_lvl <= 2'h2;
        wr8(2'h2, OFF_CONTROL, 8'h0f);
        repeat (2) @(posedge clock_i);
        en_lvl <= 2'h0;
        repeat (8) @(posedge clock_i);
        rd8(2'h2, OFF_RELOAD_LO);
        chk(8'h34, d);
        rd8(2'h2, OFF_RELOAD_HI);
        chk(8'h12, d);
        rd8(2'h2, OFF_CONTROL);
        chk(8'h4f, d);
        chk(8'h04, {5'h0, irq});
        $display("test capture done");
        wr8(2'h2, OFF_CONTROL, 8'h0f);
        wr8(2'h2, OFF_CONFIG, 8'h01);
        wr8(2'h2, OFF_COUNT_LO, 8'h00);
        wr8(2'h2, OFF_COUNT_HI, 8'h00);
        en_lvl <= 2'h2;
        repeat (4) @(posedge clock_i);
        en_lvl <= 2'h0;
        repeat (4) @(posedge clock_i);
        cnt_lvl <= 2'h1;
        repeat (4) @(posedge clock_i);
        cnt_lvl <= 2'h3;
        repeat (6) @(posedge clock_i);
        rd8(2'h2, OFF_COUNT_LO);
        chk(8'hff, d);
        rd8(2'h2, OFF_CONTROL);
        chk(8'h8f, d);
        rd8(2'h2, OFF_RELOAD_LO);
        chk(8'h34, d);
        $display("test count down done");
        // A window of 120 cycles holds a whole number of periods of every prescaler.
        for (int m = 0; m < 4; m++) begin
            wr8(2'h1, OFF_CONFIG, {3'h0, m[1:0], 3'h0});
            wr8(2'h1, OFF_COUNT_LO, 8'h00);
            wr8(2'h1, OFF_CONTROL, 8'h04);
            repeat (118) @(posedge clock_i);
            wr8(2'h1, OFF_CONTROL, 8'h00);
            rd8(2'h1, OFF_COUNT_LO);
            chk(mode_ticks[m], d);
        end
        $display("test clock modes done");
        en_lvl <= 2'h1;
        wr8(2'h0, OFF_CONFIG, 8'h00);
        wr8(2'h0, OFF_COUNT_LO, 8'h55);
        wr8(2'h0, OFF_CONTROL, 8'h0e);
        wr8(2'h1, OFF_CONTROL, 8'h0f);
        en_lvl <= 2'h0;
        repeat (6) @(posedge clock_i);
        rd8(2'h0, OFF_COUNT_LO);
        chk(8'h00, d);
        rd8(2'h1, OFF_RELOAD_LO);
        chk(8'h3c, d);
        $display("test shared pin done");
        rstn_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        chk(8'h00, {3'h0, oe_o, irq});
        rstn_i <= 1'b1;
        rd8(2'h1, OFF_COUNT_LO);
        chk(8'h00, d);
        rd8(2'h0, OFF_CONTROL);
        chk(8'h00, d);
        $display("test reset done");
        summarize();
    end
endmodule
